// File: design/bram_fifo_pkg.sv
// Constants and types shared by the block RAM and its FIFO mode.
// Assumes a single system clock; all fabric controls arrive on that clock.
package bram_fifo_pkg;

  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int RAM_DEPTH  = 16;

  // Write behaviour select codes on the mode pins
  localparam logic [1:0] MODE_SEL_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_SEL_THROUGH = 2'h1;
  localparam logic [1:0] MODE_SEL_RBW     = 2'h2;

  typedef enum logic [2:0] {
    WM_NORMAL  = 3'b001,
    WM_THROUGH = 3'b010,
    WM_RBW     = 3'b100
  } write_mode_e;

  localparam logic [ADDR_W-1:0] PTR_RESET   = 4'h0;
  localparam logic [ADDR_W-1:0] EMPTY_LEVEL = 4'h0;
  localparam logic [DATA_W-1:0] DOUT_RESET  = 8'h00;

  // Flag values while and after a global reset
  localparam logic FULL_RESET   = 1'b0;
  localparam logic AFULL_RESET  = 1'b0;
  localparam logic AEMPTY_RESET = 1'b1;
  localparam logic EMPTY_RESET  = 1'b1;

endpackage

// File: design/embedded_block_ram.sv
// Block RAM with selectable write behaviour plus a flag-generating FIFO.
// Assumes fabric user logic on CLK_SYS_I drives every control input.
`timescale 1ns/1ps
`default_nettype none

module bram_fifo_core
  import bram_fifo_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  localparam int AW   = $clog2(DEPTH)
) (
  // Clock and resets
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             clear_i,
  input  wire logic             rp_clear_i,
  // Thresholds
  input  wire logic [AW-1:0]    full_level_i,
  input  wire logic [AW-1:0]    af_level_i,
  input  wire logic [AW-1:0]    ae_level_i,
  // Fill side
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Drain side
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic      [WIDTH-1:0] rd_data_o,
  // Flags
  output logic                  full_o,
  output logic                  af_o,
  output logic                  ae_o,
  output logic                  empty_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW-1:0]    next_wptr;
  logic [AW-1:0]    next_rptr;
  logic [AW-1:0]    next_count;
  logic [AW-1:0]    count;
  logic             wr_take;
  logic             rd_take;

  // One slot stays unused so pointer distance never wraps to zero when full
  assign wr_ready_o = ~full_o;
  assign rd_valid_o = ~empty_o;
  assign wr_take    = wr_valid_i & wr_ready_o;
  assign rd_take    = rd_ready_i & rd_valid_o;
  assign rd_data_o  = mem[rptr];
  assign count      = wptr - rptr;

  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    if (clear_i) begin
      next_wptr = AW'(PTR_RESET);
      next_rptr = AW'(PTR_RESET);
    end else begin
      if (wr_take) begin
        next_wptr = wptr + 1'b1;
      end
      if (rp_clear_i) begin
        next_rptr = AW'(PTR_RESET);
      end else if (rd_take) begin
        next_rptr = rptr + 1'b1;
      end
    end
    next_count = next_wptr - next_rptr;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr <= AW'(PTR_RESET);
      rptr <= AW'(PTR_RESET);
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Storage has no reset; pointers alone define contents
  always_ff @(posedge clk_i) begin
    if (wr_take && !clear_i) begin
      mem[wptr] <= wr_data_i;
    end
  end

  // Write-side flags
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      full_o <= FULL_RESET;
      af_o   <= AFULL_RESET;
    end else if (clear_i) begin
      full_o <= FULL_RESET;
      af_o   <= AFULL_RESET;
    end else begin
      full_o <= next_count >= full_level_i;
      af_o   <= next_count >= af_level_i;
    end
  end

  // Read-side flags
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      empty_o <= EMPTY_RESET;
      ae_o    <= AEMPTY_RESET;
    end else if (clear_i) begin
      empty_o <= EMPTY_RESET;
      ae_o    <= AEMPTY_RESET;
    end else begin
      empty_o <= next_count == AW'(EMPTY_LEVEL);
      ae_o    <= next_count <= ae_level_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_full_holds_wptr;
    full_o && wr_valid_i && !clear_i |=> $stable(wptr);
  endproperty
  a_full_holds_wptr: assert property (p_full_holds_wptr)
    else $error("write taken while full");

  property p_empty_holds_rptr;
    empty_o && rd_ready_i && !clear_i && !rp_clear_i |=> $stable(rptr);
  endproperty
  a_empty_holds_rptr: assert property (p_empty_holds_rptr)
    else $error("read taken while empty");

  property p_empty_tracks_count;
    empty_o && wr_valid_i && !clear_i && !rp_clear_i |=> !empty_o;
  endproperty
  a_empty_tracks_count: assert property (p_empty_tracks_count)
    else $error("write into an empty fifo left the empty flag set");

  property p_full_tracks_count;
    !$past(clear_i) && $stable(full_level_i) |-> full_o == (count >= full_level_i);
  endproperty
  a_full_tracks_count: assert property (p_full_tracks_count)
    else $error("full flag disagrees with occupancy");

  sequence s_cleared;
    empty_o && ae_o && !full_o && !af_o && wptr == AW'(PTR_RESET) && rptr == AW'(PTR_RESET);
  endsequence

  property p_global_clear;
    clear_i |=> s_cleared;
  endproperty
  a_global_clear: assert property (p_global_clear)
    else $error("global reset left state behind");

  property p_rp_clear;
    rp_clear_i && !clear_i && !wr_valid_i |=> rptr == AW'(PTR_RESET) && $stable(wptr);
  endproperty
  a_rp_clear: assert property (p_rp_clear)
    else $error("read pointer reset disturbed write pointer");

endmodule

module embedded_block_ram
  import bram_fifo_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              NRST_I,
  // RAM port
  input  wire logic              RAM_CE_I,
  input  wire logic              RAM_OCE_I,
  input  wire logic              RAM_CS_I,
  input  wire logic              RAM_WE_I,
  input  wire logic [1:0]        RAM_MODE_I,
  input  wire logic [ADDR_W-1:0] RAM_ADDR_I,
  input  wire logic [DATA_W-1:0] RAM_DIN_I,
  output logic      [DATA_W-1:0] RAM_DOUT_O,
  // FIFO resets and thresholds
  input  wire logic              FIFO_CLEAR_I,
  input  wire logic              READ_POINTER_CLEAR_I,
  input  wire logic [ADDR_W-1:0] FULL_LEVEL_I,
  input  wire logic [ADDR_W-1:0] ALMOST_FULL_LEVEL_I,
  input  wire logic [ADDR_W-1:0] ALMOST_EMPTY_LEVEL_I,
  // FIFO write side
  input  wire logic              WRITE_CLOCK_ENABLE_I,
  input  wire logic              WRITE_ENABLE_I,
  input  wire logic              WRITE_CHIP_SELECT_I,
  input  wire logic              FULL_INPUT_GATE_I,
  input  wire logic [DATA_W-1:0] WRITE_DATA_I,
  // FIFO read side
  input  wire logic              READ_CLOCK_ENABLE_I,
  input  wire logic              OUTPUT_FETCH_ENABLE_I,
  input  wire logic              READ_CHIP_SELECT_I,
  input  wire logic              EMPTY_INPUT_GATE_I,
  input  wire logic              OUTPUT_LATCH_ENABLE_I,
  output logic      [DATA_W-1:0] READ_DATA_O,
  // FIFO flags
  output logic                   FULL_FLAG_O,
  output logic                   ALMOST_FULL_FLAG_O,
  output logic                   ALMOST_EMPTY_FLAG_O,
  output logic                   EMPTY_FLAG_O
);

  logic [DATA_W-1:0] ram [RAM_DEPTH];
  logic [DATA_W-1:0] old_word;
  write_mode_e       mode;
  logic              ram_take;
  logic              fifo_wr_valid;
  logic              fifo_pop;
  logic              fifo_rd_valid;
  logic              fifo_rd_ready;
  logic [DATA_W-1:0] fifo_rd_data;

  // Unknown codes fall back to the safe normal behaviour
  always_comb begin
    case (RAM_MODE_I)
      MODE_SEL_NORMAL:  mode = WM_NORMAL;
      MODE_SEL_THROUGH: mode = WM_THROUGH;
      MODE_SEL_RBW:     mode = WM_RBW;
      default:          mode = WM_NORMAL;
    endcase
  end

  assign ram_take = RAM_CE_I & RAM_CS_I;
  assign old_word = ram[RAM_ADDR_I];

  always_ff @(posedge CLK_SYS_I) begin
    if (ram_take && RAM_WE_I) begin
      ram[RAM_ADDR_I] <= RAM_DIN_I;
    end
  end

  // Output register loads only with output enable, so it can hold a result
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RAM_DOUT_O <= DOUT_RESET;
    end else if (ram_take && RAM_OCE_I) begin
      if (!RAM_WE_I) begin
        RAM_DOUT_O <= old_word;
      end else begin
        case (mode)
          WM_NORMAL:  RAM_DOUT_O <= RAM_DOUT_O;
          WM_THROUGH: RAM_DOUT_O <= RAM_DIN_I;
          WM_RBW:     RAM_DOUT_O <= old_word;
          default:    RAM_DOUT_O <= RAM_DOUT_O;
        endcase
      end
    end
  end

  // Gate inputs behave as second chip-select bits
  assign fifo_wr_valid = WRITE_CLOCK_ENABLE_I & WRITE_ENABLE_I
                       & WRITE_CHIP_SELECT_I & FULL_INPUT_GATE_I;
  assign fifo_rd_ready = READ_CLOCK_ENABLE_I & OUTPUT_FETCH_ENABLE_I
                       & READ_CHIP_SELECT_I & EMPTY_INPUT_GATE_I;

  bram_fifo_core #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i        (CLK_SYS_I),
    .nrst_i       (NRST_I),
    .clear_i      (FIFO_CLEAR_I),
    .rp_clear_i   (READ_POINTER_CLEAR_I),
    .full_level_i (FULL_LEVEL_I),
    .af_level_i   (ALMOST_FULL_LEVEL_I),
    .ae_level_i   (ALMOST_EMPTY_LEVEL_I),
    .wr_valid_i   (fifo_wr_valid),
    .wr_ready_o   (),
    .wr_data_i    (WRITE_DATA_I),
    .rd_valid_o   (fifo_rd_valid),
    .rd_ready_i   (fifo_rd_ready),
    .rd_data_o    (fifo_rd_data),
    .full_o       (FULL_FLAG_O),
    .af_o         (ALMOST_FULL_FLAG_O),
    .ae_o         (ALMOST_EMPTY_FLAG_O),
    .empty_o      (EMPTY_FLAG_O)
  );

  // Clears win over a read, so the read register must not load either
  assign fifo_pop = fifo_rd_ready & fifo_rd_valid & ~FIFO_CLEAR_I & ~READ_POINTER_CLEAR_I;

  // A read with the latch enable low still pops the word; it is just not shown
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      READ_DATA_O <= DOUT_RESET;
    end else if (fifo_pop && OUTPUT_LATCH_ENABLE_I) begin
      READ_DATA_O <= fifo_rd_data;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  property p_normal_write;
    ram_take && RAM_OCE_I && RAM_WE_I && RAM_MODE_I == MODE_SEL_NORMAL |=> $stable(RAM_DOUT_O);
  endproperty
  a_normal_write: assert property (p_normal_write)
    else $error("normal write changed the output");

  sequence s_through_write;
    ram_take && RAM_OCE_I && RAM_WE_I && RAM_MODE_I == MODE_SEL_THROUGH;
  endsequence

  property p_through_write;
    s_through_write |=> RAM_DOUT_O == $past(RAM_DIN_I);
  endproperty
  a_through_write: assert property (p_through_write)
    else $error("write-through output is not the written word");

  property p_rbw_write;
    ram_take && RAM_OCE_I && RAM_WE_I && RAM_MODE_I == MODE_SEL_RBW
      |=> RAM_DOUT_O == $past(old_word) ##1 1'b1;
  endproperty
  a_rbw_write: assert property (p_rbw_write)
    else $error("read-before-write output is not the old word");

  property p_gate_blocks_write;
    !FULL_INPUT_GATE_I && !FIFO_CLEAR_I |=> $stable(u_fifo.wptr);
  endproperty
  a_gate_blocks_write: assert property (p_gate_blocks_write)
    else $error("write taken with full gate low");

  property p_clear_holds_read_data;
    READ_POINTER_CLEAR_I || FIFO_CLEAR_I |=> $stable(READ_DATA_O);
  endproperty
  a_clear_holds_read_data: assert property (p_clear_holds_read_data)
    else $error("read data loaded during a pointer clear");

endmodule

`default_nettype wire

// File: verif/fifo_reader_model.sv
// Fabric reader on the FIFO read side.
// Assumes the bench clock; outputs change only at its falling edge.
`timescale 1ns/1ps
`default_nettype none
module fifo_reader_model (
  // Control
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic slow_i,
  // Read side
  output logic      rce_o,
  output logic      fetch_o,
  output logic      cs_o,
  output logic      gate_o,
  output logic      latch_o
);
  // Slow mode drops single gates, as busy fabric would
  initial begin
    {rce_o, fetch_o, cs_o, gate_o, latch_o} = 5'h00;
    forever begin
      @(negedge clk_i);
      rce_o   = run_i && (!slow_i || $urandom % 4 != 0);
      fetch_o = run_i && (!slow_i || $urandom % 4 != 0);
      cs_o    = run_i && (!slow_i || $urandom % 8 != 0);
      gate_o  = run_i && (!slow_i || $urandom % 8 != 0);
      latch_o = !slow_i || $urandom % 2 != 0;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the block RAM and its FIFO mode.
// Assumes one clock; bench drives writes and RAM, the reader model drains.
`timescale 1ns/1ps
`default_nettype none
module tb
  import bram_fifo_pkg::*;
;
  logic              clk, nrst, ce, output_register_enable, cs, we, clr, rpclr, write_clock_enable, wen, write_chip_select, fgate, run, slow;
  logic              read_clock_enable, rfe, read_chip_select, egate, output_latch_enable, ff, aff, aef, ef;
  logic [1:0]        mode;
  logic [ADDR_W-1:0] addr, lf, laf, lae, wp, rp, c;
  logic [DATA_W-1:0] din, wdat, rdat, dout, dexp, rexp, d;
  logic [DATA_W-1:0] ram_sh [RAM_DEPTH];
  logic [DATA_W-1:0] mem [FIFO_DEPTH];
  logic [DATA_W-1:0] rq [$];
  int                mismatches, cmp_count, cyc;

  embedded_block_ram u_dut (
    .CLK_SYS_I(clk), .NRST_I(nrst), .RAM_CE_I(ce), .RAM_OCE_I(output_register_enable), .RAM_CS_I(cs),
    .RAM_WE_I(we), .RAM_MODE_I(mode), .RAM_ADDR_I(addr), .RAM_DIN_I(din), .RAM_DOUT_O(dout),
    .FIFO_CLEAR_I(clr), .READ_POINTER_CLEAR_I(rpclr), .FULL_LEVEL_I(lf),
    .ALMOST_FULL_LEVEL_I(laf), .ALMOST_EMPTY_LEVEL_I(lae), .WRITE_CLOCK_ENABLE_I(write_clock_enable),
    .WRITE_ENABLE_I(wen), .WRITE_CHIP_SELECT_I(write_chip_select), .FULL_INPUT_GATE_I(fgate),
    .WRITE_DATA_I(wdat), .READ_CLOCK_ENABLE_I(read_clock_enable), .OUTPUT_FETCH_ENABLE_I(rfe),
    .READ_CHIP_SELECT_I(read_chip_select), .EMPTY_INPUT_GATE_I(egate), .OUTPUT_LATCH_ENABLE_I(output_latch_enable),
    .READ_DATA_O(rdat), .FULL_FLAG_O(ff), .ALMOST_FULL_FLAG_O(aff),
    .ALMOST_EMPTY_FLAG_O(aef), .EMPTY_FLAG_O(ef));

  fifo_reader_model u_rd (.clk_i(clk), .run_i(run), .slow_i(slow), .rce_o(read_clock_enable),
    .fetch_o(rfe), .cs_o(read_chip_select), .gate_o(egate), .latch_o(output_latch_enable));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string nm, input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic ram_op(input logic [1:0] m, input logic w, input logic [2:0] en, input logic [3:0] a);
    @(negedge clk);
    {ce, cs, output_register_enable} = en;
    mode = m;
    we = w;
    addr = a;
    din = DATA_W'($urandom);
  endtask

  // Gaps drop a random set of gates to vary the request
  task automatic wr_burst(input int n, input logic gaps);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      {write_clock_enable, wen, write_chip_select, fgate} = gaps ? 4'($urandom | $urandom) : 4'hF;
      wdat = DATA_W'($urandom);
    end
    @(negedge clk);
    {write_clock_enable, wen, write_chip_select, fgate} = 4'h0;
  endtask

  task automatic wait_empty();
    for (int i = 0; i < 400 && ef !== 1'b1; i++) @(negedge clk);
    check("empty_reached", 8'(ef), 8'h01);
  endtask

  // Reference of pointers, storage and RAM, updated on each rising edge
  always @(posedge clk) begin
    if (!nrst || clr) begin
      wp = '0;
      rp = '0;
    end else begin
      if (read_clock_enable & rfe & read_chip_select & egate & !ef & !rpclr & output_latch_enable) rq.push_back(mem[rp]);
      if (write_clock_enable & wen & write_chip_select & fgate & !ff) begin
        mem[wp] = wdat;
        wp++;
      end
      if (rpclr) rp = '0;
      else if (read_clock_enable & rfe & read_chip_select & egate & !ef) rp++;
    end
    if (!nrst) dexp = DOUT_RESET;
    else if (ce && cs) begin
      d = ram_sh[addr];
      if (we) ram_sh[addr] = din;
      if (output_register_enable && !we) dexp = d;
      else if (output_register_enable && mode == MODE_SEL_THROUGH) dexp = din;
      else if (output_register_enable && mode == MODE_SEL_RBW) dexp = d;
    end
  end

  always @(posedge clk) begin
    #1;
    if (!nrst) rexp = DOUT_RESET;
    if (rq.size() > 0) rexp = rq.pop_front();
    c = wp - rp;
    check("read_data", rdat, rexp);
    check("ram_dout", dout, dexp);
    check("full", 8'(ff), 8'(c >= lf));
    check("almost_full", 8'(aff), 8'(c >= laf));
    check("almost_empty", 8'(aef), 8'(c <= lae));
    check("empty", 8'(ef), 8'(c == EMPTY_LEVEL));
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    {nrst, ce, output_register_enable, cs, we, clr, rpclr, write_clock_enable, wen, write_chip_select, fgate, run, slow} = '0;
    {mode, addr, din, wdat, wp, rp} = '0;
    {lf, laf, lae} = {4'hC, 4'hA, 4'h3};
    dexp = DOUT_RESET;
    rexp = DOUT_RESET;
    void'($urandom(55));
    repeat (8) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    // Fill first so read-before-write has a known old word
    for (int a = 0; a < RAM_DEPTH; a++) ram_op(2'h0, 1'b1, 3'h7, 4'(a));
    for (int i = 0; i < 64; i++) ram_op(i[1:0], i[2], i < 16 ? 3'h7 : 3'($urandom), 4'($urandom));
    ram_op(2'h0, 1'b0, 3'h0, 4'h0);
    wr_burst(15, 1'b0);
    @(posedge clk) {run, slow} = 2'b11;
    wait_empty();
    repeat (5) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      @(negedge clk) lf = 4'(2 + $urandom % 14);
      laf = 4'(1 + $urandom % (lf - 1));
      lae = 4'(1 + $urandom % (lf - 1));
      wr_burst(40, 1'b1);
      wait_empty();
    end
    @(posedge clk) run = 1'b0;
    @(negedge clk) {lf, laf, lae} = {4'hF, 4'hE, 4'h1};
    wr_burst(6, 1'b0);
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    wr_burst(5, 1'b0);
    @(posedge clk) {run, slow} = 2'b10;
    repeat (3) @(posedge clk);
    @(negedge clk) rpclr = 1'b1;
    @(negedge clk) rpclr = 1'b0;
    @(posedge clk) run = 1'b1;
    wait_empty();
    @(posedge clk) run = 1'b0;
    wr_burst(16, 1'b0);
    @(negedge clk) nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
